/* File: hw/nfcfg_pkg.sv */
// Constants shared by the frontend configuration register bank.
// Assumes a 32-bit APB slave with one register per aligned word.
package nfcfg_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CRC_LOW = 10'h022;
  localparam logic [9:0] IDX_N_OFF = 10'h023;
  localparam logic [9:0] IDX_MOD_WIDTH = 10'h024;
  localparam logic [9:0] IDX_BIT_PHASE = 10'h025;
  localparam logic [9:0] IDX_RF_CFG = 10'h026;
  localparam logic [9:0] IDX_STATUS = 10'h030;
  // Reset values
  localparam logic [7:0] RST_CRC_LOW = 8'hFF;
  localparam logic [7:0] RST_N_OFF = 8'h88;
  localparam logic [7:0] RST_MOD_WIDTH = 8'h26;
  localparam logic [7:0] RST_BIT_PHASE = 8'h87;
  localparam logic [7:0] RST_RF_CFG = 8'h48;
  // Field positions
  localparam int IDLE_MSB = 7;
  localparam int IDLE_LSB = 4;
  localparam int MOD_MSB = 3;
  localparam int MOD_LSB = 0;
  localparam int DEMOD_CLK_BIT = 7;
  localparam int PHASE_MSB = 6;
  localparam int AMP_BIT = 7;
  localparam int GAIN_MSB = 6;
  localparam int GAIN_LSB = 4;
  localparam int SENS_MSB = 3;
  // Subcarrier period in carrier clocks
  localparam logic [4:0] SUB_PERIOD = 5'h10;
  // Receiver gain in dB
  localparam logic [5:0] GAIN_18 = 6'h12;
  localparam logic [5:0] GAIN_23 = 6'h17;
  localparam logic [5:0] GAIN_33 = 6'h21;
  localparam logic [5:0] GAIN_38 = 6'h26;
  localparam logic [5:0] GAIN_43 = 6'h2B;
  localparam logic [5:0] GAIN_48 = 6'h30;
  // Transmit delay states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_FIRE = 3'b100
  } tx_state_t;
endpackage : nfcfg_pkg

/* File: hw/nfcfg_drive_if.sv */
// Carrier between the register bank and its N-driver selector.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface nfcfg_drive_if;
  logic [7:0] off_fields;
  logic [7:0] on_fields;
  logic driver_on;
  logic powerdown;
  logic modulating;
  logic load_mod;
  logic [3:0] n_conduct;
  modport cfg (output off_fields, on_fields, driver_on, powerdown,
    modulating, load_mod, input n_conduct);
  modport drv (input off_fields, on_fields, driver_on, powerdown,
    modulating, load_mod, output n_conduct);
endinterface : nfcfg_drive_if

/* File: hw/nfcfg_drive.sv */
// N-driver conductance selector for the antenna drivers.
// Assumes the register bank drives the interface from its input pins and flip-flops.
`timescale 1ns/1ps
module nfcfg_drive (
  nfcfg_drive_if.drv drv
);
  import nfcfg_pkg::*;
  logic use_off;
  logic [3:0] pick;

  // Off fields serve while the driver is off and for load modulation
  assign use_off = ~drv.driver_on | drv.load_mod;

  // Idle or modulation field, then soft power-down forces the MSB
  always_comb begin
    if (use_off) begin
      pick = drv.modulating ? drv.off_fields[MOD_MSB:MOD_LSB]
                            : drv.off_fields[IDLE_MSB:IDLE_LSB];
    end else begin
      pick = drv.modulating ? drv.on_fields[MOD_MSB:MOD_LSB]
                            : drv.on_fields[IDLE_MSB:IDLE_LSB];
    end
    drv.n_conduct = {pick[3] | drv.powerdown, pick[2:0]};
  end
endmodule : nfcfg_drive

/* File: hw/nfcfg_regs.sv */
// Configuration register bank of the contactless frontend, with
// modulation timing, transmit delay and receiver settings.
// Assumes an APB master, a one-cycle carrier tick and synchronous inputs.
//
// Overview of operation
// - The low CRC byte is read-only and valid while the done flag is 1.
// - The idle off-conductance applies while the driver is off or load modulation is on.
// - The modulation off-conductance applies while driver is off or load modulation is on.
// - Soft power-down forces the MSB of every N-conductance to 1.
// - Load modulation uses the driver-off conductance values.
// - As initiator a Miller pulse lasts the width field plus one ticks.
// - As target the subcarrier low is width mod 8 plus 1, high 16-low.
// - Bit 7 of the bit-phase register clocks the demodulator from field.
// - The 7-bit bit-phase adds carrier clocks before transmit starts.
// - The 3-bit gain field selects 18 to 48 dB as tabled.
// - Bit 7 of the RF configuration enables the level detector amp.
// - Bits 3 to 0 of the RF configuration set detector sensitivity.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module nfcfg_regs (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [7:0] CRC_LOW_IN,
  input wire logic CRC_DONE_IN,
  input wire logic [7:0] N_ON_FIELDS_IN,
  input wire logic DRIVER_ON_IN,
  input wire logic POWERDOWN_IN,
  input wire logic LOAD_MOD_IN,
  input wire logic INITIATOR_IN,
  input wire logic TARGET_IN,
  input wire logic CARRIER_TICK_IN,
  input wire logic MILLER_START_IN,
  input wire logic TX_REQ_IN,
  output logic MILLER_PULSE_OUT,
  output logic SUBCARRIER_OUT,
  output logic TX_START_OUT,
  output logic [3:0] N_CONDUCT_OUT,
  output logic DEMOD_CLK_FIELD_OUT,
  output logic [5:0] GAIN_DB_OUT,
  output logic AMP_ENABLE_OUT,
  output logic [3:0] SENSITIVITY_OUT
);
  import nfcfg_pkg::*;
  logic [7:0] n_off_q;
  logic [7:0] width_q;
  logic [7:0] phase_q;
  logic [7:0] rf_cfg_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [9:0] idx;
  logic aligned;
  logic wr_en;
  logic [7:0] rd_d;
  logic rd_hit;
  logic miller_q;
  logic [7:0] miller_cnt_q;
  logic sub_q;
  logic [3:0] sub_cnt_q;
  logic [3:0] sub_low;
  logic [3:0] sub_high;
  tx_state_t tx_q;
  logic [6:0] tx_cnt_q;
  logic [5:0] gain_q;
  logic [3:0] n_conduct_q;
  nfcfg_drive_if dif ();

  assign idx = PADDR_IN[11:2];
  assign aligned = (PADDR_IN[1:0] == 2'h0);
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & ~slverr_q;

  // Read decode, unmapped or unaligned addresses are flagged
  always_comb begin
    rd_d = 8'h00;
    rd_hit = aligned;
    if (idx == IDX_CRC_LOW) begin
      rd_d = CRC_LOW_IN;
    end else if (idx == IDX_N_OFF) begin
      rd_d = n_off_q;
    end else if (idx == IDX_MOD_WIDTH) begin
      rd_d = width_q;
    end else if (idx == IDX_BIT_PHASE) begin
      rd_d = phase_q;
    end else if (idx == IDX_RF_CFG) begin
      rd_d = rf_cfg_q;
    end else if (idx == IDX_STATUS) begin
      rd_d = {3'h0, tx_q == TX_WAIT, miller_q, POWERDOWN_IN,
              DRIVER_ON_IN, CRC_DONE_IN};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Setup cycle captures the answer; access cycle completes at once
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (PSEL_IN & ~PENABLE_IN) begin
      prdata_q <= {24'h00_0000, rd_d};
      slverr_q <= ~rd_hit | (PWRITE_IN & (idx == IDX_CRC_LOW ||
                  idx == IDX_STATUS));
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = PSEL_IN & PENABLE_IN;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & slverr_q;

  // Writable configuration registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      n_off_q <= RST_N_OFF;
      width_q <= RST_MOD_WIDTH;
      phase_q <= RST_BIT_PHASE;
      rf_cfg_q <= RST_RF_CFG;
    end else if (wr_en) begin
      if (idx == IDX_N_OFF) begin
        n_off_q <= PWDATA_IN[7:0];
      end else if (idx == IDX_MOD_WIDTH) begin
        width_q <= PWDATA_IN[7:0];
      end else if (idx == IDX_BIT_PHASE) begin
        phase_q <= PWDATA_IN[7:0];
      end else if (idx == IDX_RF_CFG) begin
        rf_cfg_q <= PWDATA_IN[7:0];
      end
    end
  end

  // Miller pulse of width plus one carrier ticks
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      miller_q <= 1'b0;
      miller_cnt_q <= 8'h00;
    end else if (~miller_q) begin
      if (MILLER_START_IN & INITIATOR_IN) begin
        miller_q <= 1'b1;
        miller_cnt_q <= width_q;
      end
    end else if (CARRIER_TICK_IN) begin
      if (miller_cnt_q == 8'h00) begin
        miller_q <= 1'b0;
      end else begin
        miller_cnt_q <= miller_cnt_q - 8'h01;
      end
    end
  end

  // Subcarrier phase lengths from the width field
  assign sub_low = {1'b0, width_q[2:0]} + 4'h1;
  assign sub_high = 4'(SUB_PERIOD - {1'b0, sub_low});

  // Subcarrier generator, high when not acting as target
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      sub_q <= 1'b1;
      sub_cnt_q <= 4'h0;
    end else if (~TARGET_IN) begin
      sub_q <= 1'b1;
      sub_cnt_q <= 4'h0;
    end else if (CARRIER_TICK_IN) begin
      if (sub_cnt_q == 4'h0) begin
        sub_q <= ~sub_q;
        sub_cnt_q <= sub_q ? sub_low - 4'h1 : sub_high - 4'h1;
      end else begin
        sub_cnt_q <= sub_cnt_q - 4'h1;
      end
    end
  end

  // Transmit start delayed by the bit-phase count of carrier ticks
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      tx_q <= TX_IDLE;
      tx_cnt_q <= 7'h00;
    end else begin
      case (tx_q)
        TX_IDLE: begin
          if (TX_REQ_IN) begin
            tx_cnt_q <= phase_q[PHASE_MSB:0];
            tx_q <= (phase_q[PHASE_MSB:0] == 7'h00) ? TX_FIRE : TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (CARRIER_TICK_IN) begin
            tx_cnt_q <= tx_cnt_q - 7'h01;
            if (tx_cnt_q == 7'h01) begin
              tx_q <= TX_FIRE;
            end
          end
        end
        TX_FIRE: begin
          tx_q <= TX_IDLE;
        end
        default: begin
          tx_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign TX_START_OUT = (tx_q == TX_FIRE);

  // Receiver gain decode, registered
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      gain_q <= GAIN_33;
    end else begin
      case (rf_cfg_q[GAIN_MSB:GAIN_LSB])
        3'h0, 3'h2: gain_q <= GAIN_18;
        3'h1, 3'h3: gain_q <= GAIN_23;
        3'h4: gain_q <= GAIN_33;
        3'h5: gain_q <= GAIN_38;
        3'h6: gain_q <= GAIN_43;
        default: gain_q <= GAIN_48;
      endcase
    end
  end

  // Driver selector connection and registered conductance
  assign dif.off_fields = n_off_q;
  assign dif.on_fields = N_ON_FIELDS_IN;
  assign dif.driver_on = DRIVER_ON_IN;
  assign dif.powerdown = POWERDOWN_IN;
  assign dif.modulating = miller_q | (LOAD_MOD_IN & ~sub_q);
  assign dif.load_mod = LOAD_MOD_IN;

  nfcfg_drive nfcfg_drive_i (
    .drv(dif.drv)
  );

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      n_conduct_q <= 4'h8;
    end else begin
      n_conduct_q <= dif.n_conduct;
    end
  end

  // Pin outputs straight from flip-flops
  assign N_CONDUCT_OUT = n_conduct_q;
  assign MILLER_PULSE_OUT = miller_q;
  assign SUBCARRIER_OUT = sub_q;
  assign DEMOD_CLK_FIELD_OUT = phase_q[DEMOD_CLK_BIT];
  assign GAIN_DB_OUT = gain_q;
  assign AMP_ENABLE_OUT = rf_cfg_q[AMP_BIT];
  assign SENSITIVITY_OUT = rf_cfg_q[SENS_MSB:0];

  // Helper counters of carrier ticks for the checks
  logic [8:0] mil_ticks_q;
  logic [4:0] low_ticks_q;
  logic [7:0] tx_ticks_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN | ~miller_q) begin
      mil_ticks_q <= 9'h000;
    end else if (CARRIER_TICK_IN) begin
      mil_ticks_q <= mil_ticks_q + 9'h001;
    end
  end
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN | sub_q) begin
      low_ticks_q <= 5'h00;
    end else if (CARRIER_TICK_IN) begin
      low_ticks_q <= low_ticks_q + 5'h01;
    end
  end
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN | (tx_q == TX_IDLE)) begin
      tx_ticks_q <= 8'h00;
    end else if (CARRIER_TICK_IN & (tx_q == TX_WAIT)) begin
      tx_ticks_q <= tx_ticks_q + 8'h01;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  sequence crc_read_setup;
    PSEL_IN & ~PENABLE_IN & ~PWRITE_IN & aligned & (idx == IDX_CRC_LOW);
  endsequence

  AST_CRC_READ: assert property (
    crc_read_setup |=> PRDATA_OUT[7:0] == $past(CRC_LOW_IN))
    else $error("CRC low byte read mismatch");
  AST_IDLE_OFF: assert property (
    ~DRIVER_ON_IN & ~dif.modulating & ~POWERDOWN_IN
    |=> N_CONDUCT_OUT == $past(n_off_q[IDLE_MSB:IDLE_LSB]))
    else $error("Idle conductance not from off field");
  AST_MOD_ON: assert property (
    DRIVER_ON_IN & ~LOAD_MOD_IN & dif.modulating & ~POWERDOWN_IN
    |=> N_CONDUCT_OUT == $past(N_ON_FIELDS_IN[MOD_MSB:MOD_LSB]))
    else $error("Modulation conductance not from on field");
  AST_PD_MSB: assert property (
    POWERDOWN_IN |=> N_CONDUCT_OUT[3])
    else $error("Power-down did not force conductance MSB");
  AST_LOAD_OFF: assert property (
    LOAD_MOD_IN & dif.modulating
    |=> N_CONDUCT_OUT[2:0] == $past(n_off_q[MOD_MSB-1:MOD_LSB]))
    else $error("Load modulation not from off field");
  AST_MILLER_LEN: assert property (
    $fell(miller_q) |-> mil_ticks_q == {1'b0, width_q} + 9'h001)
    else $error("Miller pulse length wrong");
  AST_SUB_LOW: assert property (
    $rose(sub_q) & TARGET_IN & $stable(width_q)
    |-> low_ticks_q == {1'b0, sub_low})
    else $error("Subcarrier low phase length wrong");
  AST_DEMOD: assert property (
    wr_en & (idx == IDX_BIT_PHASE)
    |=> DEMOD_CLK_FIELD_OUT == $past(PWDATA_IN[DEMOD_CLK_BIT]))
    else $error("Demodulator clock select not updated");
  AST_TX_DELAY: assert property (
    $rose(TX_START_OUT)
    |-> tx_ticks_q == {1'b0, phase_q[PHASE_MSB:0]})
    else $error("Transmit delay count wrong");
  AST_GAIN: assert property (
    rf_cfg_q[GAIN_MSB:GAIN_LSB] == 3'h4 ##1 $stable(rf_cfg_q)
    |-> GAIN_DB_OUT == GAIN_33)
    else $error("Gain code 100 not 33 dB");
  AST_RESET_VAL: assert property (
    @(posedge CLK_SYS_IN) $past(RESET_IN) |-> n_off_q == RST_N_OFF &&
    width_q == RST_MOD_WIDTH && phase_q == RST_BIT_PHASE)
    else $error("Reset values not loaded");
endmodule : nfcfg_regs

/* File: dv/nfcfg_regs_tb.sv */
// Self-checking bench for the frontend configuration register bank.
// Assumes the bank's APB slave answers without wait states.
`timescale 1ns/1ps
module nfcfg_regs_tb;
  import nfcfg_pkg::*;
  logic clk, rst, psel, pen, pwr, cdone, dron, pd, lmod, ini, tgt;
  logic tick = 1'b0;
  logic mst, trq;
  logic [11:0] paddr;
  logic [31:0] pwd, prd;
  logic [7:0] crc, non;
  logic [1:0] tc = 2'd0;
  logic prdy, perr, mpulse, subc, txs, demod, amp;
  logic [3:0] ncond, sens;
  logic [5:0] gain;
  int fails, samples_checked;
  nfcfg_regs nfcfg_regs_i (.CLK_SYS_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .CRC_LOW_IN(crc), .CRC_DONE_IN(cdone), .N_ON_FIELDS_IN(non),
    .DRIVER_ON_IN(dron), .POWERDOWN_IN(pd), .LOAD_MOD_IN(lmod),
    .INITIATOR_IN(ini), .TARGET_IN(tgt), .CARRIER_TICK_IN(tick),
    .MILLER_START_IN(mst), .TX_REQ_IN(trq), .MILLER_PULSE_OUT(mpulse),
    .SUBCARRIER_OUT(subc), .TX_START_OUT(txs), .N_CONDUCT_OUT(ncond),
    .DEMOD_CLK_FIELD_OUT(demod), .GAIN_DB_OUT(gain),
    .AMP_ENABLE_OUT(amp), .SENSITIVITY_OUT(sens));
  // Clock and a carrier tick every fourth cycle
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tc <= tc + 2'd1;
    tick <= (tc == 2'd3);
  end
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, {24'h0, d}, r, e);
  endtask : wr
  // Reset values through the bus and at the outputs
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    logic [7:0] rv [4] = '{8'h88, 8'h26, 8'h87, 8'h48};
    for (int i = 0; i < 4; i++) begin
      apb(12'h08C + 12'(4 * i), 1'b0, 32'h0, r, e);
      chk("reset_value", {24'h0, rv[i]}, r);
    end
    chk("demod_rst", 1, demod);
    chk("amp_rst", 0, amp);
    chk("sens_rst", 4'h8, sens);
    chk("gain_rst", GAIN_33, gain);
  endtask : t_reset
  // Read-only CRC byte, status flag, refused accesses, write and readback
  task automatic t_bus();
    logic [31:0] r;
    logic e;
    apb(12'h088, 1'b0, 32'h0, r, e);
    chk("crc_low", 32'hC3, r);
    apb(12'h0C0, 1'b0, 32'h0, r, e);
    chk("crc_done", 1, r[0]);
    apb(12'h088, 1'b1, 32'h5A, r, e);
    chk("crc_wr_err", 1, e);
    apb(12'h0FC, 1'b0, 32'h0, r, e);
    chk("unmapped_err", 1, e);
    apb(12'h090, 1'b1, 32'hA5, r, e);
    apb(12'h090, 1'b0, 32'h0, r, e);
    chk("width_rb", 32'hA5, r);
  endtask : t_bus
  // Every gain code, with detector amp and sensitivity alongside
  task automatic t_gain();
    logic [5:0] gt [8] = '{GAIN_18, GAIN_23, GAIN_18, GAIN_23, GAIN_33,
      GAIN_38, GAIN_43, GAIN_48};
    for (int c = 0; c < 8; c++) begin
      wr(12'h098, {c[0], c[2:0], 1'b0, c[2:0]});
      @(posedge clk);
      chk("gain", gt[c], gain);
      chk("amp", c[0], amp);
      chk("sens", c[2:0], sens);
    end
  endtask : t_gain
  // Idle conductance under driver, power-down and load modulation
  task automatic t_cond();
    logic [3:0] ex [5] = '{4'h5, 4'h3, 4'hB, 4'hD, 4'h5};
    logic [2:0] in [5] = '{3'b000, 3'b100, 3'b110, 3'b010, 3'b101};
    wr(12'h08C, 8'h5A);
    for (int i = 0; i < 5; i++) begin
      {dron, pd, lmod} <= in[i];
      repeat (3) @(posedge clk);
      chk("n_conduct", ex[i], ncond);
    end
    {dron, pd, lmod} <= 3'b000;
  endtask : t_cond
  // Miller pulse length in ticks; modulation conductance while it runs
  task automatic t_miller();
    int n, k;
    wr(12'h090, 8'h02);
    ini <= 1'b1;
    mst <= 1'b1;
    @(posedge clk);
    mst <= 1'b0;
    @(posedge clk);
    chk("miller_rise", 1, mpulse);
    n = 0;
    k = 0;
    while (mpulse === 1'b1 && k < 200) begin
      if (tick) n++;
      k++;
      if (k == 3) chk("n_mod", 4'hA, ncond);
      if (k == 3) dron <= 1'b1;
      if (k == 6) chk("n_mod_on", 4'h1, ncond);
      @(posedge clk);
    end
    chk("miller_ticks", 3, n);
    ini <= 1'b0;
    dron <= 1'b0;
  endtask : t_miller
  // Subcarrier duty from width modulo 8
  task automatic t_sub();
    int n, k;
    wr(12'h090, 8'h0B);
    tgt <= 1'b1;
    {dron, lmod} <= 2'b11;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (subc !== 1'b0 && k < 200);
    for (int lv = 0; lv < 2; lv++) begin
      n = 0;
      k = 0;
      while (subc === lv[0] && k < 200) begin
        if (tick) n++;
        k++;
        if (lv == 0 && k == 3) chk("n_load", 4'hA, ncond);
        @(posedge clk);
      end
      chk("sub_phase", lv ? 12 : 4, n);
    end
    {tgt, dron, lmod} <= 3'b000;
  endtask : t_sub
  // Transmit delay in ticks, zero and nonzero, demod source bit
  task automatic t_tx();
    int n, k;
    logic [6:0] ph [2] = '{7'h00, 7'h03};
    for (int i = 0; i < 2; i++) begin
      wr(12'h094, {1'b0, ph[i]});
      chk("demod", 0, demod);
      while (tick !== 1'b1) @(posedge clk);
      trq <= 1'b1;
      @(posedge clk);
      trq <= 1'b0;
      n = 0;
      k = 0;
      @(posedge clk);
      while (txs !== 1'b1 && k < 300) begin
        if (tick) n++;
        k++;
        @(posedge clk);
      end
      chk("tx_ticks", ph[i], n);
    end
    wr(12'h094, 8'h83);
    chk("demod_set", 1, demod);
  endtask : t_tx
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Watchdog at about ten times the expected run length
  initial begin
    #20000;
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    {rst, psel, pen, pwr, paddr, pwd} = {1'b1, 3'b000, 12'h0, 32'h0};
    {cdone, dron, pd, lmod, ini, tgt, mst, trq} = 8'h80;
    crc = 8'hC3;
    non = 8'h31;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bus();
    t_gain();
    t_cond();
    t_miller();
    t_sub();
    t_tx();
    complete_run();
  end
endmodule : nfcfg_regs_tb
